// ### gofm_defines.vh
// Purpose: constants for the general-purpose pin output function multiplexer
// Assumes: one core clock, synchronous active-low reset
// Notes: select codes are the programmed field encodings
// Function
// - port 1 source, codes 0-3 route inputs
// - port 1 codes 4/5 give lock, pass
// - port 1 codes 6/7 give frame/line valid
// - status source code 0 drives constant value
// - status code 1 ORs enabled port locks
// - status code 2 ANDs enabled port locks
// - status code 3 ANDs enabled port pass
// - status code 4 outputs frame sync
// - status codes 5/6 interrupt high, low
// - transmit codes 0/1 give pass AND, OR
// - transmit code 2 gives recovered frame valid
// - transmit code 3 gives recovered line valid
// - transmit code 4 gives ports synchronized
// - transmit code 5 gives transmit interrupt high
// - port 0 source, codes 0-3 route inputs
`ifndef GOFM_DEFINES_VH
`define GOFM_DEFINES_VH
// ********************
// source selects
// ********************
`define GOFM_SRC_PORT0 3'h0
`define GOFM_SRC_PORT1 3'h1
`define GOFM_SRC_STATUS 3'h4
`define GOFM_SRC_CSITX 3'h5
// ********************
// function selects
// ********************
`define GOFM_FN_0 3'h0
`define GOFM_FN_1 3'h1
`define GOFM_FN_2 3'h2
`define GOFM_FN_3 3'h3
`define GOFM_FN_4 3'h4
`define GOFM_FN_5 3'h5
`define GOFM_FN_6 3'h6
`define GOFM_FN_7 3'h7
// ********************
// reset values and synchroniser depth
// ********************
`define GOFM_RST_SRC 3'h0
`define GOFM_RST_FN 3'h0
`define GOFM_RST_PIN 1'b0
`define GOFM_SYNC_STAGES 2
`endif

// ### gofm_sync.v
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs asynchronous to CLOCK
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module gofm_sync
#(
  parameter WIDTH = 1
)
(
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // gofm_sync

// ### gofm_pin_mux.v
// Purpose: per-pin output source and function multiplexer
// Assumes: status inputs come from other clock domains or pins
// Notes: select bits are plain ports; one pin per instance
`timescale 1ns/1ns
`include "gofm_defines.vh"
module gofm_pin_mux
#(
  parameter NUM_PORTS = 2
)
(
  input wire CLOCK,
  input wire RST_N,
  input wire [2:0] OUTPUT_SOURCE_SELECT,
  input wire [2:0] OUTPUT_FUNCTION_SELECT,
  input wire OUTPUT_CONSTANT_VALUE,
  input wire OUTPUT_DRIVE_ENABLE,
  input wire [3:0] PORT0_FWD_IN,
  input wire [3:0] PORT1_FWD_IN,
  input wire [NUM_PORTS-1:0] PORT_LOCK,
  input wire [NUM_PORTS-1:0] PORT_PASS,
  input wire [NUM_PORTS-1:0] PORT_ENABLED,
  input wire [NUM_PORTS-1:0] PORT_SELECTED,
  input wire PORT0_FRAME_VALID,
  input wire PORT0_LINE_VALID,
  input wire PORT1_FRAME_VALID,
  input wire PORT1_LINE_VALID,
  input wire FRAME_SYNC_SIGNAL,
  input wire DEVICE_INTERRUPT,
  input wire TX_FRAME_VALID,
  input wire TX_LINE_VALID,
  input wire PORTS_ALIGNED,
  input wire TX_INTERRUPT,
  output reg PIN_OUT,
  output reg PIN_OE,
  output reg RESERVED_SELECT
);
  // ********************
  // input synchronisation
  // ********************
  localparam SW = 8 + 4 * NUM_PORTS + 10;
  wire [SW-1:0] raw_in;
  wire [SW-1:0] sync_in;
  assign raw_in = {PORT0_FWD_IN, PORT1_FWD_IN, PORT_LOCK, PORT_PASS,
    PORT_ENABLED, PORT_SELECTED, PORT0_FRAME_VALID, PORT0_LINE_VALID,
    PORT1_FRAME_VALID, PORT1_LINE_VALID, FRAME_SYNC_SIGNAL,
    DEVICE_INTERRUPT, TX_FRAME_VALID, TX_LINE_VALID, PORTS_ALIGNED,
    TX_INTERRUPT};
  gofm_sync #(.WIDTH(SW)) u_sync
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .d(raw_in),
    .q(sync_in)
  );
  wire [3:0] fwd0;
  wire [3:0] fwd1;
  wire [NUM_PORTS-1:0] lock_s;
  wire [NUM_PORTS-1:0] pass_s;
  wire [NUM_PORTS-1:0] en_s;
  wire [NUM_PORTS-1:0] sel_s;
  wire fv0, lv0, fv1, lv1, fsync, dev_int, tx_fv, tx_lv, aligned, tx_int;
  assign {fwd0, fwd1, lock_s, pass_s, en_s, sel_s, fv0, lv0, fv1, lv1,
    fsync, dev_int, tx_fv, tx_lv, aligned, tx_int} = sync_in;
  // ********************
  // port combining
  // ********************
  // disabled ports (unselected ports, for the transmit pass terms) are neutral: 0 for OR, 1 for AND
  wire [NUM_PORTS-1:0] lock_or_t;
  wire [NUM_PORTS-1:0] lock_and_t;
  wire [NUM_PORTS-1:0] pass_and_t;
  wire [NUM_PORTS-1:0] spass_and_t;
  wire [NUM_PORTS-1:0] spass_or_t;
  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i = i + 1)
    begin : g_port
      assign lock_or_t[i] = lock_s[i] & en_s[i];
      assign lock_and_t[i] = lock_s[i] | ~en_s[i];
      assign pass_and_t[i] = pass_s[i] | ~en_s[i];
      assign spass_and_t[i] = pass_s[i] | ~sel_s[i];
      assign spass_or_t[i] = pass_s[i] & sel_s[i];
    end
  endgenerate
  wire any_en;
  wire any_sel;
  assign any_en = |en_s;
  assign any_sel = |sel_s;
  // with no port enabled (no port selected, for the transmit pass AND) the AND terms read low rather than vacuously high
  wire lock_or;
  wire lock_and;
  wire pass_and;
  wire spass_and;
  wire spass_or;
  assign lock_or = |lock_or_t;
  assign lock_and = (&lock_and_t) & any_en;
  assign pass_and = (&pass_and_t) & any_en;
  assign spass_and = (&spass_and_t) & any_sel;
  assign spass_or = |spass_or_t;
  // ********************
  // output selection
  // ********************
  reg val_d;
  reg ok_d;
  always @*
  begin
    val_d = 1'b0;
    ok_d = 1'b1;
    case (OUTPUT_SOURCE_SELECT)
      `GOFM_SRC_PORT0:
      begin
        case (OUTPUT_FUNCTION_SELECT)
          `GOFM_FN_4: val_d = lock_s[0];
          `GOFM_FN_5: val_d = pass_s[0];
          `GOFM_FN_6: val_d = fv0;
          `GOFM_FN_7: val_d = lv0;
          default: val_d = fwd0[OUTPUT_FUNCTION_SELECT[1:0]];
        endcase
      end
      `GOFM_SRC_PORT1:
      begin
        case (OUTPUT_FUNCTION_SELECT)
          `GOFM_FN_4: val_d = lock_s[1];
          `GOFM_FN_5: val_d = pass_s[1];
          `GOFM_FN_6: val_d = fv1;
          `GOFM_FN_7: val_d = lv1;
          default: val_d = fwd1[OUTPUT_FUNCTION_SELECT[1:0]];
        endcase
      end
      `GOFM_SRC_STATUS:
      begin
        case (OUTPUT_FUNCTION_SELECT)
          `GOFM_FN_0: val_d = OUTPUT_CONSTANT_VALUE;
          `GOFM_FN_1: val_d = lock_or;
          `GOFM_FN_2: val_d = lock_and;
          `GOFM_FN_3: val_d = pass_and;
          `GOFM_FN_4: val_d = fsync;
          `GOFM_FN_5: val_d = dev_int;
          `GOFM_FN_6: val_d = ~dev_int;
          default: ok_d = 1'b0;
        endcase
      end
      `GOFM_SRC_CSITX:
      begin
        case (OUTPUT_FUNCTION_SELECT)
          `GOFM_FN_0: val_d = spass_and;
          `GOFM_FN_1: val_d = spass_or;
          `GOFM_FN_2: val_d = tx_fv;
          `GOFM_FN_3: val_d = tx_lv;
          `GOFM_FN_4: val_d = aligned;
          `GOFM_FN_5: val_d = tx_int;
          default: ok_d = 1'b0;
        endcase
      end
      default: ok_d = 1'b0;
    endcase
  end
  // ********************
  // pin register
  // ********************
  // input enable ordering is software's job; the pad sees only this enable
  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      PIN_OUT <= `GOFM_RST_PIN;
      PIN_OE <= 1'b0;
      RESERVED_SELECT <= 1'b0;
    end
    else
    begin
      PIN_OE <= OUTPUT_DRIVE_ENABLE & ok_d;
      PIN_OUT <= (OUTPUT_DRIVE_ENABLE & ok_d) ? val_d : 1'b0;
      RESERVED_SELECT <= ~ok_d;
    end
  end
endmodule // gofm_pin_mux

// ### gofm_monitor.sv
// Purpose: port checker for the pin output multiplexer
// Assumes: one clock, sync active-low reset
// Notes: status paths get three edges, so held() waits five
`timescale 1ns/1ns
module gofm_monitor
#(
  parameter NUM_PORTS = 2
)
(
  input wire CLOCK,
  input wire RST_N,
  input wire [2:0] OUTPUT_SOURCE_SELECT,
  input wire [2:0] OUTPUT_FUNCTION_SELECT,
  input wire OUTPUT_CONSTANT_VALUE,
  input wire OUTPUT_DRIVE_ENABLE,
  input wire [3:0] PORT0_FWD_IN,
  input wire [3:0] PORT1_FWD_IN,
  input wire [NUM_PORTS-1:0] PORT_LOCK,
  input wire [NUM_PORTS-1:0] PORT_ENABLED,
  input wire DEVICE_INTERRUPT,
  input wire PORTS_ALIGNED,
  input wire PIN_OUT,
  input wire PIN_OE,
  input wire RESERVED_SELECT
);
  // ****
  // checks
  // ****
  wire [5:0] sf = {OUTPUT_SOURCE_SELECT, OUTPUT_FUNCTION_SELECT};
  wire on = OUTPUT_DRIVE_ENABLE;
  wire rsv = sf[5:4] == 2'h1 || sf[5:4] == 2'h3 || sf == 6'h27 || sf > 6'h2d;
  wire [17+2*NUM_PORTS:0] ins = {sf, on, OUTPUT_CONSTANT_VALUE, PORT0_FWD_IN,
    PORT1_FWD_IN, PORT_LOCK, PORT_ENABLED, DEVICE_INTERRUPT, PORTS_ALIGNED};
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // inputs must sit still long enough to cross the synchroniser
  sequence held(c); (c && $stable(ins))[*5]; endsequence
  drive_off_a: assert property (!on |=> !PIN_OE && !PIN_OUT)
    else $error("pin driven while disabled");
  reserved_sel_a: assert property (rsv |=> RESERVED_SELECT && !PIN_OE
    && !PIN_OUT) else $error("reserved select drove the pin");
  const_level_a: assert property (on && sf == 6'h20 |=> PIN_OE
    && PIN_OUT == $past(OUTPUT_CONSTANT_VALUE)) else $error("bad constant");
  port0_fwd_a: assert property (held(on && sf < 6'h04)
    |-> PIN_OUT == PORT0_FWD_IN[sf[1:0]]) else $error("bad port 0 input");
  port1_fwd_a: assert property (held(on && sf[5:2] == 4'h2)
    |-> PIN_OUT == PORT1_FWD_IN[sf[1:0]]) else $error("bad port 1 input");
  lock_or_a: assert property (held(on && sf == 6'h21)
    |-> PIN_OUT == |(PORT_LOCK & PORT_ENABLED)) else $error("bad lock or");
  irq_low_a: assert property (held(on && sf == 6'h26)
    |-> PIN_OUT == !DEVICE_INTERRUPT) else $error("bad low interrupt");
  ports_sync_a: assert property (held(on && sf == 6'h2c)
    |-> PIN_OUT == PORTS_ALIGNED) else $error("bad alignment output");
  cover property (held(on && sf == 6'h21));
  cover property (rsv ##1 RESERVED_SELECT);
  cover property (!on ##1 on && sf == 6'h20);
endmodule // gofm_monitor

// ### gofm_board_model.sv
// Purpose: board logic that samples the pin
// Assumes: pin line has a pulldown
// Notes: reports one sample per smp pulse
`timescale 1ns/1ns
module gofm_board_model
(
  input wire clk,
  input wire pin,
  input wire oe,
  input wire smp,
  output reg seen,
  output reg got
);
  // ****
  // sampler
  // ****
  always @(posedge clk)
  begin
    got <= smp;
    seen <= oe ? pin : 1'b0;
  end
endmodule // gofm_board_model

// ### gofm_pin_mux_tb_top.sv
// Purpose: sweeps every source and function code with random status
// Assumes: five cycles settle any change
// Notes: expected {reserved, enable, level} kept in a queue
`timescale 1ns/1ns
module gofm_pin_mux_tb_top;
  reg CLOCK = 0, RST_N = 0, smp = 0;
  reg [2:0] OUTPUT_SOURCE_SELECT = 0, OUTPUT_FUNCTION_SELECT = 0;
  reg OUTPUT_CONSTANT_VALUE = 0, OUTPUT_DRIVE_ENABLE = 0;
  reg [3:0] PORT0_FWD_IN = 0, PORT1_FWD_IN = 0;
  reg [1:0] PORT_LOCK = 0, PORT_PASS = 0, PORT_ENABLED = 0, PORT_SELECTED = 0;
  reg PORT0_FRAME_VALID = 0, PORT0_LINE_VALID = 0, PORT1_FRAME_VALID = 0;
  reg PORT1_LINE_VALID = 0, FRAME_SYNC_SIGNAL = 0, DEVICE_INTERRUPT = 0;
  reg TX_FRAME_VALID = 0, TX_LINE_VALID = 0, PORTS_ALIGNED = 0;
  reg TX_INTERRUPT = 0;
  wire PIN_OUT, PIN_OE, RESERVED_SELECT, seen, got;
  integer seed = 32'h754a380a, n_errors = 0, tests_run = 0, i;
  reg [2:0] q[$];
  // ****
  // expected value
  // ****
  wire [1:0] le = PORT_LOCK & PORT_ENABLED, ps = PORT_PASS & PORT_SELECTED;
  wire [7:0] g0 = {PORT0_LINE_VALID, PORT0_FRAME_VALID, PORT_PASS[0],
    PORT_LOCK[0], PORT0_FWD_IN};
  wire [7:0] g1 = {PORT1_LINE_VALID, PORT1_FRAME_VALID, PORT_PASS[1],
    PORT_LOCK[1], PORT1_FWD_IN};
  wire [7:0] g4 = {1'b0, !DEVICE_INTERRUPT, DEVICE_INTERRUPT, FRAME_SYNC_SIGNAL,
    |PORT_ENABLED && (PORT_PASS & PORT_ENABLED) == PORT_ENABLED,
    |PORT_ENABLED && le == PORT_ENABLED, |le, OUTPUT_CONSTANT_VALUE};
  wire [7:0] g5 = {2'h0, TX_INTERRUPT, PORTS_ALIGNED, TX_LINE_VALID,
    TX_FRAME_VALID, |ps, |PORT_SELECTED && ps == PORT_SELECTED};
  wire [5:0] sf = {OUTPUT_SOURCE_SELECT, OUTPUT_FUNCTION_SELECT};
  // source 011 has no group on this part, so it is left undriven too
  wire rsv = sf[5:4] == 2'h1 || sf[5:4] == 2'h3 || sf == 6'h27 || sf > 6'h2d;
  wire [31:0] g = {g5, g4, g1, g0};
  wire v = g[{sf[5], sf[3:0]}];
  wire ok = OUTPUT_DRIVE_ENABLE & !rsv;
  wire [2:0] xp = {rsv, ok, ok & v};
  gofm_pin_mux i_dut (.*);
  gofm_board_model i_brd (.clk(CLOCK), .pin(PIN_OUT), .oe(PIN_OE),
    .smp(smp), .seen(seen), .got(got));
  initial forever #10 CLOCK = ~CLOCK;
  task check(input [2:0] e, input [2:0] r);
    begin
      tests_run = tests_run + 1;
      if (r !== e)
      begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, e, r);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge CLOCK)
    if (got === 1'b1)
      check(q.pop_front(), {RESERVED_SELECT, PIN_OE, seen});
  initial
  begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1;
    // three sweeps of all 64 codes, value and enable varied per sweep
    for (i = 0; i < 192; i = i + 1)
    begin
      @(posedge CLOCK);
      smp <= 0;
      {OUTPUT_SOURCE_SELECT, OUTPUT_FUNCTION_SELECT} <= i;
      OUTPUT_DRIVE_ENABLE <= i % 7 != 3;
      OUTPUT_CONSTANT_VALUE <= i[6];
      {PORT0_FWD_IN, PORT1_FWD_IN, PORT_LOCK, PORT_PASS, PORT_ENABLED,
        PORT_SELECTED, PORT0_FRAME_VALID, PORT0_LINE_VALID, PORT1_FRAME_VALID,
        PORT1_LINE_VALID, FRAME_SYNC_SIGNAL, DEVICE_INTERRUPT, TX_FRAME_VALID,
        TX_LINE_VALID, PORTS_ALIGNED, TX_INTERRUPT} <= $random(seed);
      repeat (5) @(posedge CLOCK);
      q.push_back(xp);
      smp <= 1;
      if (i % 64 == 63)
        $display("sweep %0d done", i / 64);
    end
    // drop the last strobe so no pop meets an empty queue
    @(posedge CLOCK);
    smp <= 0;
    repeat (3) @(posedge CLOCK);
    complete_run;
  end
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule // gofm_pin_mux_tb_top
bind gofm_pin_mux gofm_monitor #(.NUM_PORTS(NUM_PORTS)) i_mon (.*);
